// file: hw/srbs_boot_seq.sv
`timescale 1ns/1ps
// serial link boot sequencer top
module srbs_boot_seq #(
  parameter logic [31:0] L2_BASE = 32'h00800000
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic [4:0]          boot_select_pins,
  input  wire logic [3:0]          cfg_pins,
  input  wire logic                link_clk,
  input  wire logic                link_valid,
  input  wire logic                link_doorbell,
  input  wire logic [31:0]         link_addr,
  input  wire logic [31:0]         link_data,
  input  wire logic                i2c_byte_valid,
  input  wire logic [7:0]          i2c_byte,
  input  wire logic                i2c_byte_last,
  input  wire logic                i2c_none,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  output logic [7:0]               main_pll,
  output logic [7:0]               phy_timer_prescale,
  output logic [3:0]               doorbell_route_reg,
  output logic [15:0]              node_id,
  output logic                     port_cfg_valid,
  output logic                     four_lane,
  output logic [2:0]               port_count,
  output logic [15:0]              serdes_ref_10khz,
  output logic [15:0]              link_rate_mbps,
  output logic                     tx_enable,
  output logic                     boot_table_mode,
  output logic                     core_hold,
  output logic [31:0]              core_boot_addr,
  output logic                     mem_wr,
  output logic [31:0]              mem_addr,
  output logic [31:0]              mem_data
);
  srbs_pkg::srbs_state_t    st_q, st_d;
  srbs_pkg::srbs_param_t    tbl, use_d, use_q;
  srbs_pkg::srbs_link_evt_t evt;
  logic        tbl_done, tbl_ok;
  logic [4:0]  sel1_q, sel2_q;
  logic [3:0]  cfg1_q, cfg2_q, strap_cfg_q, strap_cfg_d;
  logic [1:0]  boot_cfg_q, boot_cfg_d, wait_q, wait_d;
  logic        ovr_q, ovr_d;
  logic [7:0]  pll_q, pll_d, pre_q, pre_d;
  logic [3:0]  route_q, route_d;
  logic        pcv_q, pcv_d, four_q, four_d, tx_q, tx_d, tbm_q, tbm_d;
  logic [2:0]  pcnt_q, pcnt_d;
  logic [15:0] node_q, node_d, ref_q, ref_d, rate_q, rate_d;
  logic        hold_q, hold_d;
  logic [31:0] baddr_q, baddr_d, entry_q, entry_d;
  logic        mwr_q, mwr_d;
  logic [31:0] maddr_q, maddr_d, mdata_q, mdata_d;
  logic [1:0]  ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  srbs_pkg::srbs_param_t dflt;
  logic [4:0]  sel_off;

  srbs_link_rx u_link (
    .clk           (clk),
    .rst_b         (rst_b),
    .link_clk      (link_clk),
    .link_valid    (link_valid),
    .link_doorbell (link_doorbell),
    .link_addr     (link_addr),
    .link_data     (link_data),
    .evt           (evt)
  );

  srbs_param_loader u_param (
    .clk        (clk),
    .rst_b      (rst_b),
    .byte_valid (i2c_byte_valid),
    .byte_data  (i2c_byte),
    .byte_last  (i2c_byte_last),
    .src_none   (i2c_none),
    .params     (tbl),
    .done       (tbl_done),
    .ok         (tbl_ok)
  );

  // strap pins pass two flip-flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel1_q <= '0;
      sel2_q <= '0;
      cfg1_q <= '0;
      cfg2_q <= '0;
    end else begin
      sel1_q <= boot_select_pins;
      sel2_q <= sel1_q;
      cfg1_q <= cfg_pins;
      cfg2_q <= cfg1_q;
    end
  end

  assign sel_off = sel2_q - srbs_pkg::SRIO_SEL_BASE;

  // built-in table from the captured straps
  always_comb begin
    dflt           = '0;
    dflt.length    = srbs_pkg::PARAM_LEN;
    dflt.checksum  = srbs_pkg::CSUM_OFF;
    dflt.boot_mode = srbs_pkg::BOOT_MODE_SRIO;
    dflt.port      = srbs_pkg::PORT_ZERO;
    dflt.sw_pll    = {8'h00, srbs_pkg::PLL_MULT};
    dflt.node_id   = {12'h000, strap_cfg_q} + srbs_pkg::NODE_OFFSET;
    case (boot_cfg_q)
      2'h0: begin
        dflt.cfg_index = srbs_pkg::CFG_1X;
        dflt.ref_clk   = srbs_pkg::REF_125;
        dflt.link_rate = srbs_pkg::RATE_1250;
      end
      2'h1: begin
        dflt.cfg_index = srbs_pkg::CFG_4X;
        dflt.ref_clk   = srbs_pkg::REF_125;
        dflt.link_rate = srbs_pkg::RATE_3125;
      end
      2'h2: begin
        dflt.cfg_index = srbs_pkg::CFG_4X;
        dflt.ref_clk   = srbs_pkg::REF_156;
        dflt.link_rate = srbs_pkg::RATE_1250;
      end
      default: begin
        dflt.cfg_index = srbs_pkg::CFG_4X;
        dflt.ref_clk   = srbs_pkg::REF_156;
        dflt.link_rate = srbs_pkg::RATE_3125;
      end
    endcase
  end

  // sequencer next state and outputs
  always_comb begin
    st_d        = st_q;
    strap_cfg_d = strap_cfg_q;
    boot_cfg_d  = boot_cfg_q;
    wait_d      = wait_q;
    ovr_d       = ovr_q;
    use_d       = use_q;
    pll_d       = pll_q;
    pre_d       = pre_q;
    route_d     = route_q;
    pcv_d       = pcv_q;
    four_d      = four_q;
    pcnt_d      = pcnt_q;
    tx_d        = tx_q;
    tbm_d       = tbm_q;
    node_d      = node_q;
    ref_d       = ref_q;
    rate_d      = rate_q;
    hold_d      = hold_q;
    baddr_d     = baddr_q;
    entry_d     = entry_q;
    mwr_d       = 1'b0;
    maddr_d     = maddr_q;
    mdata_d     = mdata_q;
    case (st_q)
      srbs_pkg::ST_STRAP: begin
        wait_d = wait_q + 2'h1;
        if (wait_q == srbs_pkg::STRAP_WAIT) begin
          strap_cfg_d = cfg2_q;
          boot_cfg_d  = sel_off[1:0];
          st_d        = srbs_pkg::ST_PLL;
        end
      end
      srbs_pkg::ST_PLL: begin
        pll_d = srbs_pkg::PLL_MULT;
        st_d  = srbs_pkg::ST_PRESCALE;
      end
      srbs_pkg::ST_PRESCALE: begin
        pre_d   = srbs_pkg::PRESCALE_NEW;
        route_d = srbs_pkg::IRQ_DST_ZERO;
        st_d    = srbs_pkg::ST_PARAM;
      end
      srbs_pkg::ST_PARAM: begin
        use_d = dflt;
        if (tbl_done) begin
          ovr_d = tbl_ok && tbl.length == srbs_pkg::PARAM_LEN &&
                  tbl.boot_mode == srbs_pkg::BOOT_MODE_SRIO &&
                  tbl.port == srbs_pkg::PORT_ZERO;
          if (ovr_d) use_d = tbl;
          st_d = srbs_pkg::ST_PORT;
        end
      end
      srbs_pkg::ST_PORT: begin
        tx_d   = use_q.options[srbs_pkg::OPT_TX];
        tbm_d  = use_q.options[srbs_pkg::OPT_TABLE];
        node_d = use_q.node_id;
        if (!use_q.options[srbs_pkg::OPT_NOCFG]) begin
          pcv_d  = 1'b1;
          four_d = use_q.cfg_index == srbs_pkg::CFG_4X;
          pcnt_d = four_d ? 3'h1 : 3'h4;
          ref_d  = use_q.ref_clk;
          rate_d = use_q.link_rate;
        end
        st_d = srbs_pkg::ST_LOAD;
      end
      srbs_pkg::ST_LOAD: begin
        hold_d = 1'b1;
        if (evt.wr) begin
          mwr_d   = 1'b1;
          maddr_d = evt.addr;
          mdata_d = evt.data;
          if (evt.addr == srbs_pkg::ENTRY_ADDR) entry_d = evt.data;
        end
        if (evt.doorbell && !ctrl_q[0]) begin
          baddr_d = entry_q != '0 ? entry_q : L2_BASE;
          hold_d  = 1'b0;
          st_d    = srbs_pkg::ST_RUN;
        end
      end
      srbs_pkg::ST_RUN: begin
        hold_d = 1'b0;
      end
      default: st_d = srbs_pkg::ST_STRAP;
    endcase
    // restart request from software
    if (ctrl_q[1]) begin
      st_d   = srbs_pkg::ST_STRAP;
      wait_d = '0;
      hold_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q        <= srbs_pkg::ST_STRAP;
      strap_cfg_q <= '0;
      boot_cfg_q  <= '0;
      wait_q      <= '0;
      ovr_q       <= 1'b0;
      use_q       <= '0;
      pll_q       <= '0;
      pre_q       <= srbs_pkg::PRESCALE_OLD;
      route_q     <= '1;
      pcv_q       <= 1'b0;
      four_q      <= 1'b0;
      pcnt_q      <= '0;
      tx_q        <= 1'b0;
      tbm_q       <= 1'b0;
      node_q      <= '0;
      ref_q       <= '0;
      rate_q      <= '0;
      hold_q      <= 1'b1;
      baddr_q     <= '0;
      entry_q     <= '0;
      mwr_q       <= 1'b0;
      maddr_q     <= '0;
      mdata_q     <= '0;
    end else begin
      st_q        <= st_d;
      strap_cfg_q <= strap_cfg_d;
      boot_cfg_q  <= boot_cfg_d;
      wait_q      <= wait_d;
      ovr_q       <= ovr_d;
      use_q       <= use_d;
      pll_q       <= pll_d;
      pre_q       <= pre_d;
      route_q     <= route_d;
      pcv_q       <= pcv_d;
      four_q      <= four_d;
      pcnt_q      <= pcnt_d;
      tx_q        <= tx_d;
      tbm_q       <= tbm_d;
      node_q      <= node_d;
      ref_q       <= ref_d;
      rate_q      <= rate_d;
      hold_q      <= hold_d;
      baddr_q     <= baddr_d;
      entry_q     <= entry_d;
      mwr_q       <= mwr_d;
      maddr_q     <= maddr_d;
      mdata_q     <= mdata_d;
    end
  end

  // register port: control write, state readback one cycle later
  always_comb begin
    ctrl_d    = {1'b0, ctrl_q[0]};
    rdata_d   = '0;
    if (reg_wr && reg_addr == srbs_pkg::REG_CTRL) ctrl_d = reg_wdata[1:0];
    if (reg_rd) begin
      case (reg_addr)
        srbs_pkg::REG_CTRL:   rdata_d = {30'h0, ctrl_q};
        srbs_pkg::REG_STATUS: rdata_d = {20'h00000, boot_cfg_q, ovr_q, hold_q, 1'b0, st_q};
        srbs_pkg::REG_NODE:   rdata_d = {16'h0, node_q};
        srbs_pkg::REG_LINK:   rdata_d = {rate_q, ref_q};
        srbs_pkg::REG_ENTRY:  rdata_d = entry_q;
        srbs_pkg::REG_FWD:    rdata_d = {use_q.fwd_high, use_q.fwd_low};
        default:              rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q  <= '0;
      rdata_q <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata          = rdata_q;
  assign main_pll           = pll_q;
  assign phy_timer_prescale = pre_q;
  assign doorbell_route_reg = route_q;
  assign node_id            = node_q;
  assign port_cfg_valid     = pcv_q;
  assign four_lane          = four_q;
  assign port_count         = pcnt_q;
  assign serdes_ref_10khz   = ref_q;
  assign link_rate_mbps     = rate_q;
  assign tx_enable          = tx_q;
  assign boot_table_mode    = tbm_q;
  assign core_hold          = hold_q;
  assign core_boot_addr     = baddr_q;
  assign mem_wr             = mwr_q;
  assign mem_addr           = maddr_q;
  assign mem_data           = mdata_q;

  sequence s_doorbell;
    st_q == srbs_pkg::ST_LOAD && evt.doorbell && !ctrl_q[0] && !ctrl_q[1];
  endsequence

  AST_PLL_SIXTEEN: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == srbs_pkg::ST_PLL |=> pll_q == 8'h10)
    else $error("main pll not sixteen");
  AST_PRESCALE: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == srbs_pkg::ST_PARAM |-> pre_q == 8'h08)
    else $error("prescale not 0x08");
  AST_ROUTE_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == srbs_pkg::ST_LOAD |-> route_q == 4'h0)
    else $error("doorbell not routed to destination zero");
  AST_NODE_DEFAULT: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == srbs_pkg::ST_LOAD && !ovr_q) |-> node_q == {12'h000, strap_cfg_q} + 16'h0002)
    else $error("node id not strap plus two");
  AST_HOLD_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(st_q == srbs_pkg::ST_LOAD) |=> core_hold[*2])
    else $error("core not held while loading");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
    s_doorbell ##0 (entry_q == '0) |=> (!core_hold && core_boot_addr == L2_BASE))
    else $error("doorbell did not release core at l2 base");
  AST_MEM_WR: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == srbs_pkg::ST_LOAD && evt.wr && !ctrl_q[1]) |=> (mem_wr && mem_addr == $past(evt.addr)))
    else $error("host write not forwarded");
  AST_CFG0_PORTS: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == srbs_pkg::ST_PORT && !ovr_q && boot_cfg_q == 2'h0) |=>
      (port_count == 3'h4 && !four_lane && link_rate_mbps == 16'h04E2))
    else $error("configuration zero ports wrong");
  AST_NOCFG: assert property (@(posedge clk) disable iff (!rst_b)
    (st_q == srbs_pkg::ST_PORT && use_q.options[2]) |=> $stable(port_cfg_valid))
    else $error("port configured despite skip option");
endmodule

// file: hw/srbs_link_rx.sv
`timescale 1ns/1ps
// samples the host link on the local clock and turns its rising clock edges into events
module srbs_link_rx (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    link_clk,
  input  wire logic                    link_valid,
  input  wire logic                    link_doorbell,
  input  wire logic [31:0]             link_addr,
  input  wire logic [31:0]             link_data,
  output srbs_pkg::srbs_link_evt_t     evt
);
  logic [65:0] s1_q, s2_q;
  logic        c1_q, c2_q, c3_q;
  srbs_pkg::srbs_link_evt_t evt_d, evt_q;

  // two-stage synchronisers, first stage read only by second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      c1_q <= 1'b0;
      c2_q <= 1'b0;
      c3_q <= 1'b0;
    end else begin
      s1_q <= {link_valid, link_doorbell, link_addr, link_data};
      s2_q <= s1_q;
      c1_q <= link_clk;
      c2_q <= c1_q;
      c3_q <= c2_q;
    end
  end

  // capture on the synchronised rising link edge
  always_comb begin
    evt_d = '0;
    if (c2_q && !c3_q) begin
      evt_d.wr       = s2_q[65] && !s2_q[64];
      evt_d.doorbell = s2_q[64];
      evt_d.addr     = s2_q[63:32];
      evt_d.data     = s2_q[31:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) evt_q <= '0;
    else evt_q <= evt_d;
  end

  assign evt = evt_q;

  AST_EVT_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_b)
    (evt_q.wr || evt_q.doorbell) |=> !(evt_q.wr || evt_q.doorbell))
    else $error("link event longer than one cycle");
endmodule

// file: hw/srbs_param_loader.sv
`timescale 1ns/1ps
// assembles the i2c parameter table and checks its checksum
module srbs_param_loader (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 byte_valid,
  input  wire logic [7:0]           byte_data,
  input  wire logic                 byte_last,
  input  wire logic                 src_none,
  output srbs_pkg::srbs_param_t     params,
  output logic                      done,
  output logic                      ok
);
  logic [15:0] words_q [srbs_pkg::PARAM_WORDS];
  logic [15:0] words_d [srbs_pkg::PARAM_WORDS];
  logic [7:0]  hi_q, hi_d;
  logic        phase_q, phase_d;
  logic [3:0]  idx_q, idx_d;
  logic [16:0] sum_w;
  logic [15:0] sum_q, sum_d, word_w;
  logic        done_q, done_d, ok_q, ok_d;

  assign word_w = {hi_q, byte_data}; // big-endian 16-bit fields
  assign sum_w  = {1'b0, sum_q} + {1'b0, word_w};

  // byte pairing and end-around-carry sum
  always_comb begin
    words_d = words_q;
    hi_d    = hi_q;
    phase_d = phase_q;
    idx_d   = idx_q;
    sum_d   = sum_q;
    done_d  = 1'b0;
    ok_d    = ok_q;
    if (src_none) begin
      done_d = 1'b1;
      ok_d   = 1'b0;
    end else if (byte_valid) begin
      phase_d = !phase_q;
      if (!phase_q) begin
        hi_d = byte_data;
      end else begin
        sum_d = sum_w[15:0] + {15'h0000, sum_w[16]};
        if (idx_q < 4'(srbs_pkg::PARAM_WORDS)) words_d[idx_q] = word_w;
        idx_d = idx_q + 4'h1;
      end
      if (byte_last) begin
        done_d  = 1'b1;
        phase_d = 1'b0;
        idx_d   = 4'h0;
        sum_d   = '0;
        ok_d    = phase_q && (words_d[1] == srbs_pkg::CSUM_OFF ||
                  (sum_w[15:0] + {15'h0000, sum_w[16]}) == srbs_pkg::CSUM_GOOD);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < srbs_pkg::PARAM_WORDS; i++) words_q[i] <= '0;
      hi_q    <= '0;
      phase_q <= 1'b0;
      idx_q   <= '0;
      sum_q   <= '0;
      done_q  <= 1'b0;
      ok_q    <= 1'b0;
    end else begin
      words_q <= words_d;
      hi_q    <= hi_d;
      phase_q <= phase_d;
      idx_q   <= idx_d;
      sum_q   <= sum_d;
      done_q  <= done_d;
      ok_q    <= ok_d;
    end
  end

  // field order follows table offsets 0..22
  generate
    for (genvar g = 0; g < srbs_pkg::PARAM_WORDS; g++) begin : g_map
      assign params[(srbs_pkg::PARAM_WORDS-1-g)*16 +: 16] = words_q[g];
    end
  endgenerate
  assign done = done_q;
  assign ok   = ok_q;

  AST_DONE_AFTER_LAST: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_valid && byte_last && !src_none) |=> done_q)
    else $error("no done after last table byte");
  AST_NONE_NOT_OK: assert property (@(posedge clk) disable iff (!rst_b)
    src_none |=> (done_q && !ok_q))
    else $error("absent table reported as good");
endmodule

// file: hw/srbs_pkg.sv
package srbs_pkg;
  localparam logic [7:0]  PLL_MULT       = 8'h10;
  localparam logic [7:0]  PRESCALE_NEW   = 8'h08;
  localparam logic [7:0]  PRESCALE_OLD   = 8'h21;
  localparam logic [15:0] NODE_OFFSET    = 16'h0002;
  localparam logic [15:0] PARAM_LEN      = 16'h0018;
  localparam int          PARAM_WORDS    = 12;
  localparam logic [15:0] BOOT_MODE_SRIO = 16'h0106;
  localparam logic [15:0] PORT_ZERO      = 16'h0000;
  localparam int          OPT_TX         = 0;
  localparam int          OPT_TABLE      = 1;
  localparam int          OPT_NOCFG      = 2;
  localparam logic [15:0] CFG_1X         = 16'h0000;
  localparam logic [15:0] CFG_4X         = 16'h0001;
  localparam logic [15:0] REF_125        = 16'h30D4; // 10 kHz units
  localparam logic [15:0] REF_156        = 16'h3D09;
  localparam logic [15:0] RATE_1250      = 16'h04E2; // Mbps
  localparam logic [15:0] RATE_3125      = 16'h0C35;
  localparam logic [31:0] ENTRY_ADDR     = 32'h009FFFFC;
  localparam logic [3:0]  IRQ_DST_ZERO   = 4'h0;
  localparam logic [15:0] CSUM_OFF       = 16'h0000;
  localparam logic [15:0] CSUM_GOOD      = 16'hFFFF;
  localparam logic [4:0]  SRIO_SEL_BASE  = 5'h0B;
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_NODE       = 8'h08;
  localparam logic [7:0]  REG_LINK       = 8'h0C;
  localparam logic [7:0]  REG_ENTRY      = 8'h10;
  localparam logic [7:0]  REG_FWD        = 8'h14;
  localparam logic [1:0]  STRAP_WAIT     = 2'h3;

  typedef enum logic [6:0] {
    ST_STRAP    = 7'h01,
    ST_PLL      = 7'h02,
    ST_PRESCALE = 7'h04,
    ST_PARAM    = 7'h08,
    ST_PORT     = 7'h10,
    ST_LOAD     = 7'h20,
    ST_RUN      = 7'h40
  } srbs_state_t;

  typedef struct packed {
    logic [15:0] length;
    logic [15:0] checksum;
    logic [15:0] boot_mode;
    logic [15:0] port;
    logic [15:0] sw_pll;
    logic [15:0] options;
    logic [15:0] cfg_index;
    logic [15:0] node_id;
    logic [15:0] ref_clk;
    logic [15:0] link_rate;
    logic [15:0] fwd_low;
    logic [15:0] fwd_high;
  } srbs_param_t;

  typedef struct packed {
    logic        wr;
    logic        doorbell;
    logic [31:0] addr;
    logic [31:0] data;
  } srbs_link_evt_t;
endpackage

// file: verification/srbs_boot_seq_test.sv
`timescale 1ns/1ps
module srbs_boot_seq_test;
  logic        clk, rst_b, link_clk, link_valid, link_doorbell, reg_wr, reg_rd, mem_wr;
  logic        i2c_byte_valid, i2c_byte_last, i2c_none, port_cfg_valid, four_lane;
  logic        tx_enable, boot_table_mode, core_hold;
  logic [4:0]  boot_select_pins;
  logic [3:0]  cfg_pins, doorbell_route_reg;
  logic [7:0]  i2c_byte, reg_addr, main_pll, phy_timer_prescale;
  logic [2:0]  port_count;
  logic [15:0] node_id, serdes_ref_10khz, link_rate_mbps, tbl [12];
  logic [31:0] link_addr, link_data, reg_wdata, reg_rdata, core_boot_addr, mem_addr, mem_data;
  logic [31:0] rv, wa, wd;
  int          num_errors, total_checks, nw;

  srbs_boot_seq uut (.clk, .rst_b, .boot_select_pins, .cfg_pins, .link_clk, .link_valid,
    .link_doorbell, .link_addr, .link_data, .i2c_byte_valid, .i2c_byte, .i2c_byte_last,
    .i2c_none, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .main_pll,
    .phy_timer_prescale, .doorbell_route_reg, .node_id, .port_cfg_valid, .four_lane,
    .port_count, .serdes_ref_10khz, .link_rate_mbps, .tx_enable, .boot_table_mode,
    .core_hold, .core_boot_addr, .mem_wr, .mem_addr, .mem_data);
  // far end wired to lane zero
  srbs_host_model host (.link_clk, .link_valid, .link_doorbell, .link_addr, .link_data);

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // capture memory writes
  always @(posedge clk) begin
    if (mem_wr === 1'b1) begin
      nw <= nw + 1;
      wa <= mem_addr;
      wd <= mem_data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // reset with straps held, then let the sequencer reach the table wait
  task automatic boot(input logic [4:0] sel);
    @(posedge clk);
    rst_b <= 1'b0;
    boot_select_pins <= sel;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  // deliver the table bytes high first, or report no table
  task automatic load(input logic none, input logic pcv);
    int n;
    if (none) begin
      i2c_none <= 1'b1;
      @(posedge clk);
    end else begin
      for (int i = 0; i < 24; i++) begin
        i2c_byte_valid <= 1'b1;
        i2c_byte <= i[0] ? tbl[i/2][7:0] : tbl[i/2][15:8];
        i2c_byte_last <= (i == 23);
        @(posedge clk);
      end
    end
    {i2c_none, i2c_byte_valid, i2c_byte_last} <= 3'h0;
    n = 0;
    while (port_cfg_valid !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(port_cfg_valid, {31'h0, pcv});
    repeat (3) @(posedge clk);
  endtask
  // table builder; mode 0 no checksum, 1 good, 2 corrupt, 3 good with port skip
  function automatic void mk(input int mode);
    logic [16:0] s;
    tbl = '{16'h0018, 16'h0000, 16'h0106, 16'h0000, 16'h0010, 16'h0003, 16'h0001,
            16'h0077, 16'h3D09, 16'h04E2, 16'h0100, 16'h01FF};
    if (mode == 3) tbl[5] = 16'h0004;
    s = 17'h00000;
    for (int i = 0; i < 12; i++) begin
      s = {1'b0, s[15:0]} + s[16] + tbl[i];
    end
    s = {1'b0, s[15:0]} + 17'(s[16]);
    tbl[1] = (mode == 0) ? 16'h0000 : ~s[15:0] ^ {15'h0000, mode == 2};
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
  // main sequence
  initial begin
    {rst_b, reg_wr, reg_rd, i2c_byte_valid, i2c_byte_last, i2c_none} = '0;
    {boot_select_pins, cfg_pins, i2c_byte, reg_addr, reg_wdata} = '0;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      cfg_pins <= 4'hC + 4'(c);
      boot(5'h0B + 5'(c));
      load(1'b1, 1'b1);
      chk(main_pll, srbs_pkg::PLL_MULT);
      chk(phy_timer_prescale, srbs_pkg::PRESCALE_NEW);
      chk(doorbell_route_reg, srbs_pkg::IRQ_DST_ZERO);
      chk(node_id, 16'h000E + 16'(c));
      chk({four_lane, port_count, serdes_ref_10khz}, {c != 0, (c == 0) ? 3'h4 : 3'h1,
          c[1] ? srbs_pkg::REF_156 : srbs_pkg::REF_125});
      chk(link_rate_mbps, c[0] ? srbs_pkg::RATE_3125 : srbs_pkg::RATE_1250);
      chk({tx_enable, boot_table_mode, core_hold}, 32'h1);
      rd(8'h04, rv);
      chk(rv, 32'h00000120 | (32'(c) << 10));
      rd(8'h08, rv);
      chk(rv, 32'h0000000E + 32'(c));
      rd(8'h0C, rv);
      chk(rv, {c[0] ? srbs_pkg::RATE_3125 : srbs_pkg::RATE_1250,
               c[1] ? srbs_pkg::REF_156 : srbs_pkg::REF_125});
    end
    $display("strap configurations done");
    rd(8'h20, rv);
    chk(rv, 32'h0);
    @(posedge clk);
    host.xfer(1'b0, 32'h00800040, 32'hA5A55A5A);
    chk({nw[1:0], core_hold}, 32'h3);
    chk(wa, 32'h00800040);
    chk(wd, 32'hA5A55A5A);
    @(posedge clk);
    host.xfer(1'b1, 32'h0, 32'h0);
    chk(core_hold, 32'h0);
    chk(core_boot_addr, 32'h00800000);
    boot(5'h0B);
    load(1'b1, 1'b1);
    @(posedge clk);
    host.xfer(1'b0, srbs_pkg::ENTRY_ADDR, 32'h00801234);
    @(posedge clk);
    host.xfer(1'b1, 32'h0, 32'h0);
    chk(core_hold, 32'h0);
    chk(core_boot_addr, 32'h00801234);
    rd(8'h10, rv);
    chk(rv, 32'h00801234);
    $display("link load done");
    for (int m = 0; m < 4; m++) begin
      mk(m);
      boot(5'h0B);
      load(1'b0, m != 3);
      chk(node_id, (m == 2) ? 16'h0011 : 16'h0077);
      chk({tx_enable, boot_table_mode, four_lane, port_count},
          (m == 2) ? 6'h04 : (m == 3) ? 6'h00 : 6'h39);
      rd(8'h14, rv);
      chk(rv, (m == 2) ? 32'h0 : 32'h01FF0100);
    end
    wr(8'h00, 32'h1);
    @(posedge clk);
    host.xfer(1'b1, 32'h0, 32'h0);
    chk(core_hold, 32'h1);
    $display("parameter table done");
    // software restart reruns the sequence up to the table wait
    wr(8'h00, 32'h2);
    repeat (12) @(posedge clk);
    rd(8'h04, rv);
    chk(rv & 32'h0000017F, 32'h00000108);
    rd(8'h00, rv);
    chk(rv, 32'h0);
    @(posedge clk);
    load(1'b1, 1'b1);
    @(posedge clk);
    host.xfer(1'b1, 32'h0, 32'h0);
    chk(core_hold, 32'h0);
    chk(core_boot_addr, 32'h00800000);
    $display("restart done");
    close_out();
  end
endmodule

// file: verification/srbs_host_model.sv
`timescale 1ns/1ps
// host side of the link: direct memory writes and the doorbell
module srbs_host_model (
  output logic        link_clk,
  output logic        link_valid,
  output logic        link_doorbell,
  output logic [31:0] link_addr,
  output logic [31:0] link_data
);
  // idle link: clock parked low, nothing requested
  initial begin
    {link_clk, link_valid, link_doorbell, link_addr, link_data} = '0;
  end
  // one frame of 64 ns, then the bus shows the inverse of its last value
  task automatic xfer(input logic db, input logic [31:0] a, input logic [31:0] d);
    link_valid    <= ~db;
    link_doorbell <= db;
    link_addr     <= a;
    link_data     <= d;
    #32 link_clk <= 1'b1;
    #32 link_clk <= 1'b0;
    {link_valid, link_doorbell} <= 2'h0;
    link_addr <= ~a;
    link_data <= ~d;
    #64;
  endtask
endmodule
